// ==== hdl/ilc_pkg.sv ====
// Purpose: shared constants and types of the input level controller
// Assumes: 9-bit control registers written through the device control port
// Notes:   times are kept in their printed unit, counts are derived per sample rate
package ilc_pkg;

    // control register addresses
    localparam logic [6:0] ADDR_LIMITS = 7'h20;   // gain_limits_and_enable
    localparam logic [6:0] ADDR_TARGET = 7'h21;   // target_hold_zero_cross
    localparam logic [6:0] ADDR_TIMING = 7'h22;   // mode_and_rate_timing

    // reset values
    localparam logic [8:0] LIMITS_RST = 9'h038;   // ceiling 111, floor 000, off
    localparam logic [8:0] TARGET_RST = 9'h00B;   // level 1011, hold 0, zc off
    localparam logic [8:0] TIMING_RST = 9'h032;   // rise 0011, fall 0010, normal

    // field positions
    localparam int ENABLE_BIT  = 8;
    localparam int CEIL_LSB    = 3;
    localparam int FLOOR_LSB   = 0;
    localparam int ZC_BIT      = 8;
    localparam int HOLD_LSB    = 4;
    localparam int LEVEL_LSB   = 0;
    localparam int MODE_BIT    = 8;
    localparam int RISE_LSB    = 4;
    localparam int FALL_LSB    = 0;

    // rate codes at and above this value saturate
    localparam logic [3:0] RATE_CODE_SAT = 4'hA;

    // per-step times in nanoseconds, at the lowest code
    localparam longint FALL_NORM_NS = 104000;
    localparam longint RISE_NORM_NS = 410000;
    localparam longint FALL_LIM_NS  = 22700;
    localparam longint RISE_LIM_NS  = 90800;
    localparam longint HOLD_BASE_NS = 2670000;
    localparam longint NS_PER_S     = 1000000000;

    // amplifier gain code: 6 bits, 0.75 dB per code, 8 codes per 6 dB
    localparam int         GAIN_W      = 6;
    localparam logic [5:0] GAIN_RST    = 6'h10;   // 0 dB

    // target magnitudes for a 16-bit full scale, index = level code
    localparam logic [15:0] TARGET_LUT [16] = '{
        16'h04D0, 16'h05B8, 16'h06CC, 16'h0814, 16'h0999, 16'h0B68, 16'h0D8F, 16'h101D,
        16'h1327, 16'h16C3, 16'h1B0D, 16'h2027, 16'h2637, 16'h2D6B, 16'h35FA, 16'h4027};

    // controller states
    typedef enum logic [3:0] {
        ST_OFF  = 4'b0001,
        ST_HOLD = 4'b0010,
        ST_RISE = 4'b0100,
        ST_FALL = 4'b1000
    } ilc_state_e;

    // register write request
    typedef struct packed {
        logic       write;
        logic [6:0] addr;
        logic [8:0] data;
    } ilc_regwr_s;

    // one audio sample from the record path
    typedef struct packed {
        logic               tick;
        logic signed [15:0] data;
    } ilc_sample_s;

endpackage

// ==== hdl/ilc_level_ctrl.sv ====
// Purpose: automatic input gain control / peak limiter for the record amplifier
// Assumes: sample ticks and register writes are synchronous to clk
// Notes:   all timers count sample ticks, so time constants follow the sample rate
`timescale 1ns/1ps
module ilc_level_ctrl #(
    parameter int SAMPLE_RATE_HZ = 48000,
    parameter int CNT_W          = 20
) (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire ilc_pkg::ilc_regwr_s  regWr,
    input  wire logic [6:0]           regRdAddr,
    input  wire ilc_pkg::ilc_sample_s sampleIn,
    input  wire logic                 manualGainWrite,
    input  wire logic [5:0]           manualInputGain,
    output logic [8:0]                regRdData,
    output logic [5:0]                pgaGain,
    output logic                      agcActive,
    output logic                      peakAbove
);

    // base step counts in sample ticks, rounded up, never below one
    localparam longint RATE = SAMPLE_RATE_HZ;
    localparam logic [CNT_W-1:0] FALL_NORM_CNT =
        CNT_W'((ilc_pkg::FALL_NORM_NS * RATE + ilc_pkg::NS_PER_S - 1) / ilc_pkg::NS_PER_S);
    localparam logic [CNT_W-1:0] RISE_NORM_CNT =
        CNT_W'((ilc_pkg::RISE_NORM_NS * RATE + ilc_pkg::NS_PER_S - 1) / ilc_pkg::NS_PER_S);
    localparam logic [CNT_W-1:0] FALL_LIM_CNT =
        CNT_W'((ilc_pkg::FALL_LIM_NS * RATE + ilc_pkg::NS_PER_S - 1) / ilc_pkg::NS_PER_S);
    localparam logic [CNT_W-1:0] RISE_LIM_CNT =
        CNT_W'((ilc_pkg::RISE_LIM_NS * RATE + ilc_pkg::NS_PER_S - 1) / ilc_pkg::NS_PER_S);
    localparam logic [CNT_W-1:0] HOLD_BASE_CNT =
        CNT_W'((ilc_pkg::HOLD_BASE_NS * RATE + ilc_pkg::NS_PER_S - 1) / ilc_pkg::NS_PER_S);

    // control registers
    logic [8:0]              limits_reg,  limits_next;
    logic [8:0]              target_reg,  target_next;
    logic [8:0]              timing_reg,  timing_next;
    logic [8:0]              rdData_reg,  rdData_next;
    // controller state
    ilc_pkg::ilc_state_e     state_reg,   state_next;
    logic [CNT_W-1:0]        cnt_reg,     cnt_next;      // step / hold timer
    logic [16:0]             peak_reg,    peak_next;     // held peak magnitude
    logic [5:0]              gain_reg,    gain_next;     // amplifier gain code
    logic [5:0]              start_reg,   start_next;    // limiter starting gain
    logic                    limOn_reg,   limOn_next;    // limiter was running
    logic [1:0]              pend_reg,    pend_next;     // pending step: [1] up, [0] down
    logic                    sign_reg,    sign_next;     // last sample sign
    logic                    above_reg,   above_next;
    logic                    active_reg,  active_next;   // registered copy of state != OFF

    // decoded fields
    logic                    enable;
    logic                    limiter;
    logic                    zcGate;
    logic [5:0]              floorCode;
    logic [5:0]              ceilCode;
    logic [5:0]              effCeil;
    logic [3:0]              riseCode;
    logic [3:0]              fallCode;
    logic [3:0]              holdCode;
    logic [16:0]             targetMag;
    logic [CNT_W-1:0]        risePeriod;
    logic [CNT_W-1:0]        fallPeriod;
    logic [CNT_W-1:0]        holdPeriod;
    logic [16:0]             absVal;
    logic [16:0]             peakNow;
    logic                    above;
    logic                    stepUp;
    logic                    stepDown;
    logic                    zeroCross;

    // saturating doubling: base << min(code, 10)
    function automatic logic [CNT_W-1:0] scaled(input logic [CNT_W-1:0] base,
                                                input logic [3:0] code);
        logic [3:0] sh;
        sh = (code > ilc_pkg::RATE_CODE_SAT) ? ilc_pkg::RATE_CODE_SAT : code;
        return base << sh;
    endfunction

    // field decode and timer periods
    always_comb begin
        enable     = limits_reg[ilc_pkg::ENABLE_BIT];
        limiter    = timing_reg[ilc_pkg::MODE_BIT];
        zcGate     = target_reg[ilc_pkg::ZC_BIT];
        floorCode  = {limits_reg[ilc_pkg::FLOOR_LSB +: 3], 3'h0};
        ceilCode   = {limits_reg[ilc_pkg::CEIL_LSB +: 3], 3'h7};
        // limiter cannot lift gain past where it started; until the start gain is
        // latched the present gain stands in, so a step up on the switch edge is blocked
        effCeil    = (limiter && !limOn_reg) ? gain_reg
                   : (limiter && start_reg < ceilCode) ? start_reg : ceilCode;
        riseCode   = timing_reg[ilc_pkg::RISE_LSB +: 4];
        fallCode   = timing_reg[ilc_pkg::FALL_LSB +: 4];
        holdCode   = target_reg[ilc_pkg::HOLD_LSB +: 4];
        targetMag  = {1'b0, ilc_pkg::TARGET_LUT[target_reg[ilc_pkg::LEVEL_LSB +: 4]]};
        risePeriod = scaled(limiter ? RISE_LIM_CNT : RISE_NORM_CNT, riseCode);
        fallPeriod = scaled(limiter ? FALL_LIM_CNT : FALL_NORM_CNT, fallCode);
        // hold code 0 means no wait; code n waits base << (n-1)
        if (holdCode == 4'h0) begin
            holdPeriod = '0;
        end else begin
            // codes above 1010 give the same longest hold as 1010
            holdPeriod = scaled(HOLD_BASE_CNT, ((holdCode > ilc_pkg::RATE_CODE_SAT) ?
                         ilc_pkg::RATE_CODE_SAT : holdCode) - 4'h1);
        end
    end

    // peak detector on the incoming samples
    always_comb begin
        // 17 bits so that the most negative sample folds without overflow
        absVal    = sampleIn.data[15] ? 17'(-$signed({sampleIn.data[15], sampleIn.data}))
                                      : {1'b0, sampleIn.data};
        peakNow   = (sampleIn.tick && absVal > peak_reg) ? absVal : peak_reg;
        above     = peakNow > targetMag;
        zeroCross = sampleIn.tick && (sampleIn.data[15] != sign_reg);
    end

    // register file: writes and registered read-back
    always_comb begin
        limits_next = limits_reg;
        target_next = target_reg;
        timing_next = timing_reg;
        if (regWr.write) begin
            case (regWr.addr)
                ilc_pkg::ADDR_LIMITS: limits_next = regWr.data;
                ilc_pkg::ADDR_TARGET: target_next = regWr.data;
                ilc_pkg::ADDR_TIMING: timing_next = regWr.data;
                default:              limits_next = limits_reg;
            endcase
        end
        case (regRdAddr)
            ilc_pkg::ADDR_LIMITS: rdData_next = limits_reg;
            ilc_pkg::ADDR_TARGET: rdData_next = target_reg;
            ilc_pkg::ADDR_TIMING: rdData_next = timing_reg;
            default:              rdData_next = 9'h000;   // unmapped reads zero
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            limits_reg <= ilc_pkg::LIMITS_RST;
            target_reg <= ilc_pkg::TARGET_RST;
            timing_reg <= ilc_pkg::TIMING_RST;
            rdData_reg <= 9'h000;
        end else begin
            limits_reg <= limits_next;
            target_reg <= target_next;
            timing_reg <= timing_next;
            rdData_reg <= rdData_next;
        end
    end

    // level controller: timers, step decisions and gain
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        peak_next  = peak_reg;
        gain_next  = gain_reg;
        start_next = start_reg;
        pend_next  = pend_reg;
        sign_next  = sampleIn.tick ? sampleIn.data[15] : sign_reg;
        above_next = above_reg;
        limOn_next = enable && limiter;
        stepUp     = 1'b0;
        stepDown   = 1'b0;

        // starting gain is taken whenever limiting begins, from idle or normal mode
        if (enable && limiter && !limOn_reg) begin
            start_next = gain_reg;
        end

        if (!enable) begin
            // gain stays where the controller left it
            state_next = ilc_pkg::ST_OFF;
            cnt_next   = '0;
            peak_next  = '0;
            pend_next  = 2'b00;
            above_next = 1'b0;
            // manual gain is unconstrained while control is off
            if (manualGainWrite) begin
                gain_next = manualInputGain;
            end
        end else if (sampleIn.tick) begin
            peak_next  = peakNow;
            above_next = above;
            case (state_reg)
                ilc_pkg::ST_OFF: begin
                    state_next = ilc_pkg::ST_HOLD;
                    cnt_next   = '0;
                    peak_next  = '0;
                end
                ilc_pkg::ST_HOLD: begin
                    if (above) begin
                        state_next = ilc_pkg::ST_FALL;
                        cnt_next   = '0;
                    end else if (cnt_reg >= holdPeriod) begin
                        state_next = ilc_pkg::ST_RISE;
                        cnt_next   = '0;
                    end else begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
                ilc_pkg::ST_RISE: begin
                    if (above) begin
                        state_next = ilc_pkg::ST_FALL;
                        cnt_next   = '0;
                    end else if (cnt_reg + 1'b1 >= risePeriod) begin
                        stepUp    = 1'b1;
                        cnt_next  = '0;
                        peak_next = '0;
                    end else begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
                ilc_pkg::ST_FALL: begin
                    if (!above) begin
                        // a rise must always be preceded by the hold wait
                        state_next = ilc_pkg::ST_HOLD;
                        cnt_next   = '0;
                    end else if (cnt_reg + 1'b1 >= fallPeriod) begin
                        stepDown  = 1'b1;
                        cnt_next  = '0;
                        peak_next = '0;
                    end else begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
                default: begin
                    state_next = ilc_pkg::ST_OFF;
                end
            endcase

            // zero-cross gate defers the step; a newer step replaces an older one
            if (stepUp || stepDown) begin
                pend_next = {stepUp, stepDown};
            end
            if (!zcGate || zeroCross) begin
                if (pend_next[1] && gain_reg < effCeil && gain_reg < 6'h3F) begin
                    gain_next = gain_reg + 6'h01;
                end else if (pend_next[0] && gain_reg > floorCode) begin
                    gain_next = gain_reg - 6'h01;
                end
                pend_next = 2'b00;
            end
        end
        active_next = (state_next != ilc_pkg::ST_OFF);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= ilc_pkg::ST_OFF;
            cnt_reg   <= '0;
            peak_reg  <= '0;
            gain_reg  <= ilc_pkg::GAIN_RST;
            start_reg <= ilc_pkg::GAIN_RST;
            limOn_reg <= 1'b0;
            pend_reg  <= 2'b00;
            sign_reg  <= 1'b0;
            above_reg <= 1'b0;
            active_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            peak_reg  <= peak_next;
            gain_reg  <= gain_next;
            start_reg <= start_next;
            limOn_reg <= limOn_next;
            pend_reg  <= pend_next;
            sign_reg  <= sign_next;
            above_reg <= above_next;
            active_reg <= active_next;
        end
    end

    // outputs straight from flip-flops
    assign regRdData = rdData_reg;
    assign pgaGain   = gain_reg;
    assign agcActive = active_reg;
    assign peakAbove = above_reg;

endmodule

// ==== tb/ilc_level_monitor.sv ====
// Purpose: port checker for the input level controller
// Assumes: register shadows follow the write strobe exactly
// Notes:   gain limits are rebuilt from the shadowed fields
`timescale 1ns/1ps
module ilc_level_monitor (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire ilc_pkg::ilc_regwr_s  regWr,
    input  wire logic [6:0]           regRdAddr,
    input  wire ilc_pkg::ilc_sample_s sampleIn,
    input  wire logic                 manualGainWrite,
    input  wire logic [5:0]           manualInputGain,
    input  wire logic [8:0]           regRdData,
    input  wire logic [5:0]           pgaGain,
    input  wire logic                 agcActive,
    input  wire logic                 peakAbove
);
    logic [8:0] limReg;  // shadow of limits register
    logic [8:0] tgtReg;  // shadow of target register
    // shadows update on the same edge as the design copy
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            limReg <= ilc_pkg::LIMITS_RST;
            tgtReg <= ilc_pkg::TARGET_RST;
        end else if (regWr.write) begin
            if (regWr.addr == ilc_pkg::ADDR_LIMITS) limReg <= regWr.data;
            if (regWr.addr == ilc_pkg::ADDR_TARGET) tgtReg <= regWr.data;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    off_gain_still_a: assert property (
        !agcActive && !manualGainWrite |=> $stable(pgaGain))
        else $error("gain moved while control was off");
    step_one_a: assert property (
        agcActive |=> pgaGain == $past(pgaGain) || pgaGain == $past(pgaGain) + 6'h01
            || pgaGain == $past(pgaGain) - 6'h01)
        else $error("gain moved by more than one code");
    tick_only_a: assert property (
        agcActive && !sampleIn.tick |=> $stable(pgaGain))
        else $error("gain stepped without a sample tick");
    floor_hold_a: assert property (
        agcActive && pgaGain <= {limReg[2:0], 3'h0} |=> pgaGain >= $past(pgaGain))
        else $error("gain stepped below the floor");
    ceil_hold_a: assert property (
        agcActive && pgaGain >= {limReg[5:3], 3'h7} |=> pgaGain <= $past(pgaGain))
        else $error("gain stepped above the ceiling");
    peak_idle_a: assert property (
        (!agcActive) [*2] |-> !peakAbove)
        else $error("peak flag set while control off");
    off_when_clear_a: assert property (
        (!limReg[ilc_pkg::ENABLE_BIT]) [*3] |-> !agcActive)
        else $error("control active with enable clear");
    rd_limits_a: assert property (
        regRdAddr == ilc_pkg::ADDR_LIMITS |=> regRdData == $past(limReg))
        else $error("limits readback wrong");
    rd_target_a: assert property (
        regRdAddr == ilc_pkg::ADDR_TARGET |=> regRdData == $past(tgtReg))
        else $error("target readback wrong");
endmodule
bind ilc_level_ctrl ilc_level_monitor ilc_level_monitor_inst (.clk, .rst_b, .regWr,
    .regRdAddr, .sampleIn, .manualGainWrite, .manualInputGain, .regRdData, .pgaGain,
    .agcActive, .peakAbove);

// ==== tb/ilc_pga_model.sv ====
// Purpose: behavioural record amplifier feeding samples to the controller
// Assumes: mic level is a magnitude scaled by (gain code + 1) / 16
// Notes:   sign flips every sample so zero crossings are frequent
`timescale 1ns/1ps
module ilc_pga_model (
    input  wire logic            clk,
    input  wire logic            rst_b,
    input  wire logic            slow,      // one sample every two clocks
    input  wire logic [15:0]     micLevel,  // input magnitude
    input  wire logic [5:0]      pgaGain,   // gain set by the controller
    output ilc_pkg::ilc_sample_s sampleOut
);
    logic        phaseReg;  // tick divider
    logic        signReg;   // sample sign
    logic [21:0] amp;       // scaled magnitude before clipping
    logic [15:0] mag;       // clipped magnitude
    // divider toggles every clock; sign only moves on sample ticks
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phaseReg <= 1'b0;
            signReg  <= 1'b0;
        end else begin
            phaseReg <= ~phaseReg;
            if (sampleOut.tick) signReg <= ~signReg;
        end
    end
    // between ticks the data is inverted so stale samples never look valid
    always_comb begin
        amp = (22'(micLevel) * (22'(pgaGain) + 22'h1)) >> 4;
        mag = (amp > 22'h7FFF) ? 16'h7FFF : amp[15:0];
        sampleOut.tick = rst_b & (~slow | phaseReg);
        sampleOut.data = signReg ? -mag : mag;
        if (!sampleOut.tick) sampleOut.data = ~sampleOut.data;
    end
endmodule

// ==== tb/ilc_level_ctrl_tb_top.sv ====
// Purpose: directed bench for the input level controller
// Assumes: samples come from the amplifier model, one per clock unless slowed
// Notes:   48 kHz periods; tests pick the shortest rate codes
`timescale 1ns/1ps
module ilc_level_ctrl_tb_top;
    logic                 clk = 1'b0;
    logic                 rst_b = 1'b0;
    ilc_pkg::ilc_regwr_s  regWr = '0;
    logic [6:0]           regRdAddr = 7'h00;
    ilc_pkg::ilc_sample_s sampleIn;
    logic                 manualGainWrite = 1'b0;
    logic [5:0]           manualInputGain = 6'h00;
    logic [8:0]           regRdData;
    logic [5:0]           pgaGain;
    logic                 agcActive;
    logic                 peakAbove;
    logic                 slow = 1'b0;
    logic [15:0]          micLevel = 16'h0010;
    int                   errorCnt = 0;
    int                   totalChecks = 0;
    int                   n;
    logic [5:0]           g;
    logic [8:0]           rstv [4] = '{9'h038, 9'h00B, 9'h032, 9'h000};
    always #10 clk = ~clk;
    ilc_level_ctrl ilc_level_ctrl_inst (.clk(clk), .rst_b(rst_b), .regWr(regWr),
        .regRdAddr(regRdAddr), .sampleIn(sampleIn), .manualGainWrite(manualGainWrite),
        .manualInputGain(manualInputGain), .regRdData(regRdData), .pgaGain(pgaGain),
        .agcActive(agcActive), .peakAbove(peakAbove));
    ilc_pga_model ilc_pga_model_inst (.clk(clk), .rst_b(rst_b), .slow(slow),
        .micLevel(micLevel), .pgaGain(pgaGain), .sampleOut(sampleIn));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        @(negedge clk);
        regWr = '{write: 1'b1, addr: a, data: d};
        @(negedge clk);
        regWr.write = 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [8:0] e);
        @(negedge clk);
        regRdAddr = a;
        @(negedge clk);
        chk("regRdData", 16'(regRdData), 16'(e));
    endtask
    task automatic man(input logic [5:0] v);
        @(negedge clk);
        manualInputGain = v;
        manualGainWrite = 1'b1;
        @(negedge clk);
        manualGainWrite = 1'b0;
    endtask
    // bounded wait for the next gain change, counted in clocks
    task automatic waitChg(output int c);
        logic [5:0] s;
        s = pgaGain;
        c = 0;
        while (pgaGain === s && c < 2000) begin
            @(negedge clk);
            c++;
        end
        chk("waitChg", 16'(c < 2000), 16'h0001);
    endtask
    // spacing between two consecutive steps
    task automatic gap(input int e, input string nm);
        waitChg(n);
        waitChg(n);
        chk(nm, 16'(n), 16'(e));
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog, far beyond the 1400 or so clocks the tests need
    initial begin
        repeat (10000) @(posedge clk);
        errorCnt++;
        results();
    end
    initial begin
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        for (int i = 0; i < 4; i++) rd(7'h20 + 7'(i), rstv[i]);
        wr(7'h21, 9'h1FF);
        rd(7'h21, 9'h1FF);
        chk("gainRst", 16'(pgaGain), 16'h0010);
        wr(7'h20, 9'h000);  // lowest ceiling, control off
        man(6'h30);
        chk("manualGain", 16'(pgaGain), 16'h0030);
        man(6'h28);
        wr(7'h21, 9'h00B);
        wr(7'h22, 9'h000);  // normal mode, shortest rates
        micLevel = 16'h7FFF;
        wr(7'h20, 9'h13C);  // on, ceiling 111, floor 100
        gap(5, "fallGap");
        chk("peakAbove", 16'(peakAbove), 16'h0001);
        repeat (100) @(negedge clk);
        chk("floorGain", 16'(pgaGain), 16'h0020);
        slow = 1'b1;
        micLevel = 16'h0010;
        wr(7'h20, 9'h124);  // ceiling 100, floor 100
        gap(40, "riseGap");
        repeat (400) @(negedge clk);
        chk("ceilGain", 16'(pgaGain), 16'h0027);
        slow = 1'b0;
        wr(7'h21, 9'h01B);  // hold code 1
        micLevel = 16'h7FFF;
        waitChg(n);
        micLevel = 16'h0010;
        g = pgaGain;
        n = 0;
        while (!(pgaGain > g) && n < 2000) begin
            @(negedge clk);
            n++;
        end
        chk("holdWait", 16'(n >= 129 && n < 2000), 16'h0001);
        wr(7'h20, 9'h024);  // control off, limits kept
        repeat (2) @(negedge clk);
        g = pgaGain;
        micLevel = 16'h7FFF;
        repeat (50) @(negedge clk);
        chk("frozenGain", 16'(pgaGain), 16'(g));
        chk("agcActive", 16'(agcActive), 16'h0000);
        man(6'h05);
        chk("manualLow", 16'(pgaGain), 16'h0005);
        man(6'h18);
        micLevel = 16'h0010;
        wr(7'h22, 9'h100);  // limiter, shortest rates
        wr(7'h21, 9'h00B);
        wr(7'h20, 9'h1F8);  // on, ceiling 111, floor 000
        repeat (200) @(negedge clk);
        chk("limitHold", 16'(pgaGain), 16'h0018);
        chk("agcOn", 16'(agcActive), 16'h0001);
        micLevel = 16'h7FFF;
        gap(2, "limitFall");
        micLevel = 16'h0010;
        repeat (300) @(negedge clk);
        chk("limitBack", 16'(pgaGain), 16'h0018);
        chk("peakLow", 16'(peakAbove), 16'h0000);
        man(6'h00);
        chk("manualRefused", 16'(pgaGain), 16'h0018);
        results();
    end
endmodule
